// [common/jcp_regs.svh]
// Constants for the configuration array programmer.
`ifndef JCP_REGS_SVH
`define JCP_REGS_SVH
`define JCP_IR_W        8
`define JCP_IR_CAPTURE  8'h01
`define JCP_OP_ENABLE   8'h15
`define JCP_OP_DISABLE  8'h1E
`define JCP_OP_CFGERASE 8'h29
`define JCP_OP_COLSEL   8'h2B
`define JCP_OP_SHIFT    8'h2D
`define JCP_OP_PROGRAM  8'h2E
`define JCP_OP_DONEPROG 8'h2F
`define JCP_OP_BYPASS   8'hFF
`define JCP_COL_W       4
`define JCP_COLS        16
`define JCP_DATA_W      56
`define JCP_IDLE_EDGE   2'h2
`define JCP_ERASED_WORD 56'h00000000000000
`endif

// [common/jcp_pkg.sv]
// Types for the configuration array programmer.
package jcp_pkg;
  typedef enum logic [3:0] {
    TLR, RTI, SELDR, CAPDR, SHDR, EX1DR, PADR, EX2DR, UPDR,
    SELIR, CAPIR, SHIR, EX1IR, PAIR, EX2IR, UPIR
  } jcp_tap_t;
endpackage

// [rtl/jcp_tap_fsm.sv]
// TAP controller state machine.
`include "jcp_regs.svh"
module jcp_tap_fsm (
  input  wire logic          clk,
  input  wire logic          rstn,
  input  wire logic          tckRise,
  input  wire logic          tms,
  output jcp_pkg::jcp_tap_t  tapState
);
  jcp_pkg::jcp_tap_t state_q, state_d;
  assign tapState = state_q;
  always_comb begin
    state_d = state_q;
    if (tckRise) begin
      case (state_q)
        jcp_pkg::TLR:   state_d = tms ? jcp_pkg::TLR   : jcp_pkg::RTI;
        jcp_pkg::RTI:   state_d = tms ? jcp_pkg::SELDR : jcp_pkg::RTI;
        jcp_pkg::SELDR: state_d = tms ? jcp_pkg::SELIR : jcp_pkg::CAPDR;
        jcp_pkg::CAPDR: state_d = tms ? jcp_pkg::EX1DR : jcp_pkg::SHDR;
        jcp_pkg::SHDR:  state_d = tms ? jcp_pkg::EX1DR : jcp_pkg::SHDR;
        jcp_pkg::EX1DR: state_d = tms ? jcp_pkg::UPDR  : jcp_pkg::PADR;
        jcp_pkg::PADR:  state_d = tms ? jcp_pkg::EX2DR : jcp_pkg::PADR;
        jcp_pkg::EX2DR: state_d = tms ? jcp_pkg::UPDR  : jcp_pkg::SHDR;
        jcp_pkg::UPDR:  state_d = tms ? jcp_pkg::SELDR : jcp_pkg::RTI;
        jcp_pkg::SELIR: state_d = tms ? jcp_pkg::TLR   : jcp_pkg::CAPIR;
        jcp_pkg::CAPIR: state_d = tms ? jcp_pkg::EX1IR : jcp_pkg::SHIR;
        jcp_pkg::SHIR:  state_d = tms ? jcp_pkg::EX1IR : jcp_pkg::SHIR;
        jcp_pkg::EX1IR: state_d = tms ? jcp_pkg::UPIR  : jcp_pkg::PAIR;
        jcp_pkg::PAIR:  state_d = tms ? jcp_pkg::EX2IR : jcp_pkg::PAIR;
        jcp_pkg::EX2IR: state_d = tms ? jcp_pkg::UPIR  : jcp_pkg::SHIR;
        jcp_pkg::UPIR:  state_d = tms ? jcp_pkg::SELDR : jcp_pkg::RTI;
        default:        state_d = jcp_pkg::TLR;
      endcase
    end
  end
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_q <= jcp_pkg::TLR;
    end else begin
      state_q <= state_d;
    end
  end
endmodule

// [rtl/jcp_config_programmer.sv]
// Configuration array programming logic behind a test access port.
`include "jcp_regs.svh"
module jcp_config_programmer (
  input  wire logic                      clk,
  input  wire logic                      rstn,
  input  wire logic                      tck,
  input  wire logic                      tms,
  input  wire logic                      tdi,
  output logic                           tdo,
  output logic                           tdoEnN,
  output logic                           progMode,
  output logic                           doneFlag,
  output logic [`JCP_COL_W-1:0]          colAddr,
  output logic [`JCP_COLS*`JCP_DATA_W-1:0] cfgArray
);
  jcp_pkg::jcp_tap_t tapState;
  logic tckRise;
  logic tckFall;
  logic tckPrev_q;
  logic [`JCP_IR_W-1:0]   irShift_q, irShift_d, ir_q, ir_d;
  logic [`JCP_COL_W-1:0]  colShift_q, colShift_d, col_q, col_d;
  logic [`JCP_DATA_W-1:0] dataShift_q, dataShift_d;
  logic                   bypass_q, bypass_d;
  logic [1:0]             idleCnt_q, idleCnt_d;
  logic                   prog_q, prog_d, done_q, done_d;
  logic                   tdo_q, tdo_d, tdoEnN_q, tdoEnN_d;
  logic [`JCP_DATA_W-1:0] mem_q [`JCP_COLS];
  logic [`JCP_DATA_W-1:0] mem_d [`JCP_COLS];

  assign tckRise = tck & ~tckPrev_q;
  assign tckFall = ~tck & tckPrev_q;

  function automatic logic isOp(input logic [`JCP_IR_W-1:0] ir, input logic [`JCP_IR_W-1:0] op);
    isOp = (ir == op);
  endfunction

  jcp_tap_fsm u_tap (
    .clk      (clk),
    .rstn     (rstn),
    .tckRise  (tckRise),
    .tms      (tms),
    .tapState (tapState)
  );

  always_comb begin
    logic fire;
    fire        = 1'b0;
    irShift_d   = irShift_q;
    ir_d        = ir_q;
    colShift_d  = colShift_q;
    col_d       = col_q;
    dataShift_d = dataShift_q;
    bypass_d    = bypass_q;
    idleCnt_d   = idleCnt_q;
    prog_d      = prog_q;
    done_d      = done_q;
    tdo_d       = tdo_q;
    tdoEnN_d    = tdoEnN_q;
    mem_d       = mem_q;
    if (tckRise) begin
      if (tapState == jcp_pkg::RTI) begin
        if (idleCnt_q != `JCP_IDLE_EDGE) begin
          idleCnt_d = idleCnt_q + 2'h1;
        end
        fire = (idleCnt_q == `JCP_IDLE_EDGE - 2'h1);
      end else begin
        idleCnt_d = 2'h0;
      end
      case (tapState)
        jcp_pkg::TLR: begin
          ir_d   = `JCP_OP_BYPASS;
          prog_d = 1'b0;
        end
        jcp_pkg::CAPIR: irShift_d = `JCP_IR_CAPTURE;
        jcp_pkg::SHIR:  irShift_d = {tdi, irShift_q[`JCP_IR_W-1:1]};
        jcp_pkg::CAPDR: begin
          colShift_d  = col_q;
          dataShift_d = mem_q[col_q];
          bypass_d    = 1'b0;
        end
        jcp_pkg::SHDR: begin
          if (isOp(ir_q, `JCP_OP_COLSEL)) begin
            colShift_d = {tdi, colShift_q[`JCP_COL_W-1:1]};
          end else if (isOp(ir_q, `JCP_OP_SHIFT)) begin
            dataShift_d = {tdi, dataShift_q[`JCP_DATA_W-1:1]};
          end else begin
            bypass_d = tdi;
          end
        end
        default: ;
      endcase
      if (fire && prog_q) begin
        if (isOp(ir_q, `JCP_OP_CFGERASE)) begin
          for (int i = 0; i < `JCP_COLS; i++) begin
            mem_d[i] = `JCP_ERASED_WORD;
          end
        end else if (isOp(ir_q, `JCP_OP_PROGRAM)) begin
          mem_d[col_q] = dataShift_q;
        end else if (isOp(ir_q, `JCP_OP_DONEPROG)) begin
          done_d = 1'b1;
        end
      end
    end
    if (tckFall) begin
      case (tapState)
        jcp_pkg::UPIR: begin
          ir_d = irShift_q;
          if (isOp(irShift_q, `JCP_OP_ENABLE)) begin
            prog_d = 1'b1;
          end else if (isOp(irShift_q, `JCP_OP_DISABLE)) begin
            prog_d = 1'b0;
          end
        end
        jcp_pkg::UPDR: begin
          if (isOp(ir_q, `JCP_OP_COLSEL)) begin
            col_d = colShift_q;
          end
        end
        jcp_pkg::SHIR: begin
          tdo_d    = irShift_q[0];
          tdoEnN_d = 1'b0;
        end
        jcp_pkg::SHDR: begin
          tdoEnN_d = 1'b0;
          if (isOp(ir_q, `JCP_OP_COLSEL)) begin
            tdo_d = colShift_q[0];
          end else if (isOp(ir_q, `JCP_OP_SHIFT)) begin
            tdo_d = dataShift_q[0];
          end else begin
            tdo_d = bypass_q;
          end
        end
        default: tdoEnN_d = 1'b1;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tckPrev_q   <= 1'b1;
      irShift_q   <= '0;
      ir_q        <= `JCP_OP_BYPASS;
      colShift_q  <= '0;
      col_q       <= '0;
      dataShift_q <= '0;
      bypass_q    <= 1'b0;
      idleCnt_q   <= 2'h0;
      prog_q      <= 1'b0;
      done_q      <= 1'b0;
      tdo_q       <= 1'b0;
      tdoEnN_q    <= 1'b1;
      for (int i = 0; i < `JCP_COLS; i++) begin
        mem_q[i] <= `JCP_ERASED_WORD;
      end
    end else begin
      tckPrev_q   <= tck;
      irShift_q   <= irShift_d;
      ir_q        <= ir_d;
      colShift_q  <= colShift_d;
      col_q       <= col_d;
      dataShift_q <= dataShift_d;
      bypass_q    <= bypass_d;
      idleCnt_q   <= idleCnt_d;
      prog_q      <= prog_d;
      done_q      <= done_d;
      tdo_q       <= tdo_d;
      tdoEnN_q    <= tdoEnN_d;
      mem_q       <= mem_d;
    end
  end

  assign tdo      = tdo_q;
  assign tdoEnN   = tdoEnN_q;
  assign progMode = prog_q;
  assign doneFlag = done_q;
  assign colAddr  = col_q;
  for (genvar g = 0; g < `JCP_COLS; g++) begin : g_arr
    assign cfgArray[g*`JCP_DATA_W +: `JCP_DATA_W] = mem_q[g];
  end

  a_tlr_cancel: assert property (@(posedge clk) disable iff (!rstn)
    (tckRise && tapState == jcp_pkg::TLR) |=> !prog_q)
    else $error("Programming mode survived Test-Logic-Reset.");
  a_done_guard: assert property (@(posedge clk) disable iff (!rstn)
    (!done_q && !prog_q) |=> !done_q)
    else $error("Completion flag set outside programming mode.");
  a_done_second: assert property (@(posedge clk) disable iff (!rstn)
    (tckRise && prog_q && tapState == jcp_pkg::RTI && idleCnt_q == 2'h1
     && ir_q == `JCP_OP_DONEPROG) |=> done_q)
    else $error("Completion flag not set on second idle edge.");
  a_erase_all: assert property (@(posedge clk) disable iff (!rstn)
    (tckRise && prog_q && tapState == jcp_pkg::RTI && idleCnt_q == 2'h1
     && ir_q == `JCP_OP_CFGERASE) |=> (mem_q[0] == '0 && mem_q[`JCP_COLS-1] == '0))
    else $error("Erase did not clear the array.");
  a_prog_write: assert property (@(posedge clk) disable iff (!rstn)
    (tckRise && prog_q && tapState == jcp_pkg::RTI && idleCnt_q == 2'h1
     && ir_q == `JCP_OP_PROGRAM) |=> mem_q[$past(col_q)] == $past(dataShift_q))
    else $error("Column program wrote wrong data.");
  a_first_edge: assert property (@(posedge clk) disable iff (!rstn)
    (tckRise && tapState == jcp_pkg::RTI && idleCnt_q == 2'h0) |=> $stable(done_q))
    else $error("Action fired on the first idle edge.");
  a_no_prog: assert property (@(posedge clk) disable iff (!rstn)
    !prog_q |=> $stable(cfgArray))
    else $error("Array changed outside programming mode.");
  a_col_load: assert property (@(posedge clk) disable iff (!rstn)
    (tckFall && tapState == jcp_pkg::UPDR && ir_q == `JCP_OP_COLSEL)
    |=> col_q == $past(colShift_q))
    else $error("Column address not loaded on update.");
  c_enable: cover property (@(posedge clk) $rose(prog_q));
  c_done: cover property (@(posedge clk) $rose(done_q));
  c_colsel: cover property (@(posedge clk) tckFall && tapState == jcp_pkg::UPDR
    && ir_q == `JCP_OP_COLSEL);
endmodule

// [tb/jcp_host_model.sv]
// Test access port host that clocks instructions and data into the programmer.
module jcp_host_model (
  input  wire logic clk,
  output logic      tck,
  output logic      tms,
  output logic      tdi,
  input  wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    tck = 1'b1;
    tms = 1'b1;
    tdi = 1'b0;
  end
  // One test clock period: low and high for three system clocks each.
  task automatic tick(input logic m, input logic d, output logic q);
    @(posedge clk);
    tck <= 1'b0;
    tms <= m;
    tdi <= d;
    repeat (3) @(posedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (2) @(posedge clk);
  endtask
  // Mode select path, first bit in bit 0; the serial input toggles outside shifts.
  task automatic walk(input logic [7:0] path, input int n);
    logic q;
    for (int i = 0; i < n; i++) begin
      tick(path[i], ~tdi, q);
    end
  endtask
  // Full scan from Run-Test-Idle back to Run-Test-Idle, low bit first.
  task automatic shift(input logic ir, input logic [55:0] din, input int n,
                       output logic [55:0] dout);
    logic q;
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      tick(i == n - 1, din[i], q);
      dout[i] = q;
    end
    walk(8'h01, 2);
  endtask
endmodule

// [tb/jcp_config_programmer_tb_top.sv]
// Self-checking bench for the configuration array programmer.
`include "jcp_regs.svh"
module jcp_config_programmer_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic                              clk;
  logic                              rstn;
  logic                              tck;
  logic                              tms;
  logic                              tdi;
  logic                              tdo;
  logic                              tdoEnN;
  logic                              progMode;
  logic                              doneFlag;
  logic [`JCP_COL_W-1:0]             colAddr;
  logic [`JCP_COLS*`JCP_DATA_W-1:0]  cfgArray;
  logic [`JCP_COLS*`JCP_DATA_W-1:0]  expArr;
  logic [55:0]                       d;
  int                                errTotal;
  int                                checksDone;
  int                                cycles;
  jcp_config_programmer u_dut (.clk(clk), .rstn(rstn), .tck(tck), .tms(tms), .tdi(tdi),
    .tdo(tdo), .tdoEnN(tdoEnN), .progMode(progMode), .doneFlag(doneFlag),
    .colAddr(colAddr), .cfgArray(cfgArray));
  jcp_host_model u_host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errTotal++;
      endOfTest();
    end
  end
  task automatic check(input string nm, input logic [895:0] seen, input logic [895:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errTotal++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, seen);
    end
  endtask
  task automatic instr(input logic [7:0] op);
    u_host.shift(1'b1, {48'h0, op}, 8, d);
  endtask
  task automatic selCol(input logic [3:0] col);
    instr(`JCP_OP_COLSEL);
    u_host.shift(1'b0, {52'h0, col}, 4, d);
    check("colAddr", colAddr, col);
  endtask
  task automatic tRefused(input logic dn);
    logic [7:0] ops[3];
    ops = '{`JCP_OP_PROGRAM, `JCP_OP_DONEPROG, `JCP_OP_CFGERASE};
    selCol(4'h9);
    instr(`JCP_OP_SHIFT);
    u_host.shift(1'b0, 56'hA5A5_0F0F_3C3C_99, 56, d);
    for (int i = 0; i < 3; i++) begin
      instr(ops[i]);
      u_host.walk(8'h00, 2);
      check("doneFlag", doneFlag, dn);
      check("cfgArray", cfgArray, expArr);
    end
  endtask
  task automatic progCol(input logic [3:0] col, input logic [55:0] data);
    selCol(col);
    instr(`JCP_OP_SHIFT);
    u_host.shift(1'b0, data, 56, d);
    instr(`JCP_OP_PROGRAM);
    u_host.walk(8'h00, 1);
    check("cfgArray", cfgArray, expArr);
    u_host.walk(8'h00, 1);
    expArr[col*56+:56] = data;
    check("cfgArray", cfgArray, expArr);
  endtask
  task automatic tProgram();
    instr(`JCP_OP_ENABLE);
    check("progMode", progMode, 1'b1);
    instr(`JCP_OP_CFGERASE);
    u_host.walk(8'h00, 2);
    progCol(4'hF, 56'hFEDC_BA98_7654_32);
    progCol(4'h0, 56'h8000_0000_0000_01);
    instr(`JCP_OP_SHIFT);
    u_host.shift(1'b0, 56'h0, 56, d);
    check("readback", d, 56'h8000_0000_0000_01);
    instr(`JCP_OP_CFGERASE);
    u_host.walk(8'h00, 1);
    check("cfgArray", cfgArray, expArr);
    u_host.walk(8'h00, 1);
    expArr = '0;
    check("cfgArray", cfgArray, expArr);
    progCol(4'h3, 56'h0123_4567_89AB_CD);
    instr(`JCP_OP_DONEPROG);
    u_host.walk(8'h00, 2);
    check("doneFlag", doneFlag, 1'b1);
  endtask
  task automatic tTlr();
    u_host.walk(8'h1F, 6);
    check("progMode", progMode, 1'b0);
    tRefused(1'b1);
  endtask
  task automatic endOfTest();
    if (errTotal == 0 && checksDone > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask
  initial begin
    rstn = 1'b0;
    errTotal = 0;
    checksDone = 0;
    cycles = 0;
    expArr = '0;
    repeat (20) @(posedge clk);
    rstn <= 1'b1;
    repeat (2) @(posedge clk);
    check("tdoEnN", tdoEnN, 1'b1);
    check("cfgArray", cfgArray, expArr);
    u_host.walk(8'h1F, 6);
    tRefused(1'b0);
    tProgram();
    tTlr();
    endOfTest();
  end
endmodule
